// File: verilog/wwdt_top.sv
`timescale 1ns/100ps
module wwdt_top (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // watchdog oscillator, about 1 kHz
  input wire logic watchdog_osc_clock,
  // core
  input wire logic watchdog_restart_instr,
  input wire logic [7:0] boot_fuse_config,
  output logic system_reset_req,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // period code to tick count
  function automatic logic [13:0] code_ticks(input logic [3:0] code);
    code_ticks = wwdt_pkg::BASE_TICKS << (code - 4'h1);
  endfunction

  function automatic logic code_valid(input logic [3:0] code);
    code_valid = (code != 4'h0) && (code <= wwdt_pkg::CODE_MAX);
  endfunction

  logic [7:0] config_ff;
  logic lock_ff;
  logic halt_ff;
  logic fuse_loaded_ff;
  logic [2:0] unlock_cnt_ff;
  logic aw_held_ff, w_held_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic reset_req_ff;

  // osc edge detection: three flops, change counts when 2nd and 3rd agree
  logic [2:0] osc_sync_ff;
  logic osc_last_ff;
  logic tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_sync_ff <= 3'h0;
      osc_last_ff <= 1'b0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], watchdog_osc_clock};
      if (osc_sync_ff[1] == osc_sync_ff[2])
        osc_last_ff <= osc_sync_ff[2];
    end
  end
  // watchdog tick on a qualified rising edge
  assign tick = (osc_sync_ff[1] == osc_sync_ff[2]) &&
    osc_sync_ff[2] && !osc_last_ff;

  // axi write channel capture
  logic wr_go;
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  logic wr_cfg, wr_sts, wr_key, wr_dbg, unlocked, addr_ok;
  assign addr_ok = (awaddr_ff == wwdt_pkg::ADDR_CONFIG) ||
    (awaddr_ff == wwdt_pkg::ADDR_STATUS) ||
    (awaddr_ff == wwdt_pkg::ADDR_UNLOCK) ||
    (awaddr_ff == wwdt_pkg::ADDR_DEBUG);
  assign wr_cfg = wr_go && wstrb_ff[0] &&
    (awaddr_ff == wwdt_pkg::ADDR_CONFIG);
  assign wr_sts = wr_go && wstrb_ff[0] &&
    (awaddr_ff == wwdt_pkg::ADDR_STATUS);
  assign wr_key = wr_go && wstrb_ff[0] &&
    (awaddr_ff == wwdt_pkg::ADDR_UNLOCK);
  assign wr_dbg = wr_go && wstrb_ff[0] &&
    (awaddr_ff == wwdt_pkg::ADDR_DEBUG);
  assign unlocked = (unlock_cnt_ff != 3'h0);

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= wwdt_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= addr_ok ? wwdt_pkg::RESP_OKAY : wwdt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // unlock window counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_cnt_ff <= 3'h0;
    end else if (wr_key && wdata_ff[7:0] == wwdt_pkg::UNLOCK_KEY) begin
      unlock_cnt_ff <= 3'(wwdt_pkg::UNLOCK_CYCLES);
    end else if (wr_cfg || wr_sts) begin
      unlock_cnt_ff <= 3'h0;
    end else if (unlocked) begin
      unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
    end
  end

  // debug halt control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_ff <= 1'b0;
    end else if (wr_dbg) begin
      halt_ff <= wdata_ff[wwdt_pkg::HALT_BIT];
    end
  end

  // crossing handshake state
  logic cfg_busy_ff;
  logic [1:0] cfg_wait_ff;
  logic rst_busy_ff;
  logic [1:0] rst_wait_ff;
  logic cfg_apply, rst_apply;
  assign cfg_apply = cfg_busy_ff && tick && (cfg_wait_ff == 2'h0);
  assign rst_apply = rst_busy_ff && tick && (rst_wait_ff == 2'h0);

  // config and lock, fuse loaded after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_ff <= 8'h00;
      lock_ff <= 1'b0;
      fuse_loaded_ff <= 1'b0;
    end else if (!fuse_loaded_ff) begin
      fuse_loaded_ff <= 1'b1;
      config_ff <= boot_fuse_config;
      lock_ff <= (boot_fuse_config[wwdt_pkg::PERIOD_LSB +: 4] != 4'h0);
    end else begin
      if (wr_cfg && unlocked && !lock_ff && !cfg_busy_ff)
        config_ff <= wdata_ff[7:0];
      if (wr_sts && unlocked && wdata_ff[wwdt_pkg::LOCK_BIT])
        lock_ff <= 1'b1;
      else if (wr_dbg && halt_ff && wdata_ff[wwdt_pkg::LOCKCLR_BIT])
        lock_ff <= 1'b0;
    end
  end

  logic cfg_take;
  assign cfg_take = wr_cfg && unlocked && !lock_ff && !cfg_busy_ff;

  // config crossing: applied on third tick after write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_busy_ff <= 1'b0;
      cfg_wait_ff <= 2'h0;
    end else if (cfg_take) begin
      cfg_busy_ff <= 1'b1;
      cfg_wait_ff <= 2'h2;
    end else if (cfg_apply) begin
      cfg_busy_ff <= 1'b0;
    end else if (cfg_busy_ff && tick) begin
      cfg_wait_ff <= cfg_wait_ff - 2'h1;
    end
  end

  // restart crossing: two to three ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_busy_ff <= 1'b0;
      rst_wait_ff <= 2'h0;
    end else if (watchdog_restart_instr && !rst_busy_ff) begin
      rst_busy_ff <= 1'b1;
      rst_wait_ff <= 2'h2;
    end else if (rst_apply) begin
      rst_busy_ff <= 1'b0;
    end else if (rst_busy_ff && tick) begin
      rst_wait_ff <= rst_wait_ff - 2'h1;
    end
  end

  // watchdog-domain copy of config
  logic [3:0] period_ff, window_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_ff <= 4'h0;
      window_ff <= 4'h0;
    end else if (!fuse_loaded_ff) begin
      period_ff <= boot_fuse_config[wwdt_pkg::PERIOD_LSB +: 4];
      window_ff <= boot_fuse_config[wwdt_pkg::WINDOW_LSB +: 4];
    end else if (cfg_apply) begin
      period_ff <= config_ff[wwdt_pkg::PERIOD_LSB +: 4];
      window_ff <= config_ff[wwdt_pkg::WINDOW_LSB +: 4];
    end
  end

  // watchdog counter and mode
  wwdt_pkg::wwdt_state_t state_ff;
  logic [13:0] count_ff;
  logic enabled, windowed, halt_prev_ff;
  assign enabled = code_valid(period_ff);
  assign windowed = code_valid(window_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= wwdt_pkg::WWDT_OFF;
      count_ff <= 14'h0;
      halt_prev_ff <= 1'b0;
    end else begin
      halt_prev_ff <= halt_ff;
      if (!enabled || halt_ff) begin
        count_ff <= 14'h0;
        state_ff <= enabled ? wwdt_pkg::WWDT_ARM : wwdt_pkg::WWDT_OFF;
      end else if (state_ff == wwdt_pkg::WWDT_OFF ||
          (halt_prev_ff && !halt_ff)) begin
        state_ff <= wwdt_pkg::WWDT_ARM;
        count_ff <= 14'h0;
      end else if (rst_apply) begin
        count_ff <= 14'h0;
        state_ff <= windowed ? wwdt_pkg::WWDT_CLOSED :
          wwdt_pkg::WWDT_OPEN;
      end else if (tick) begin
        case (state_ff)
          wwdt_pkg::WWDT_CLOSED: begin
            if (!windowed) begin
              state_ff <= wwdt_pkg::WWDT_OPEN;
            end else if (count_ff + 14'h1 >= code_ticks(window_ff)) begin
              state_ff <= wwdt_pkg::WWDT_OPEN;
              count_ff <= 14'h0;
            end else begin
              count_ff <= count_ff + 14'h1;
            end
          end
          wwdt_pkg::WWDT_ARM, wwdt_pkg::WWDT_OPEN: begin
            if (count_ff < code_ticks(period_ff))
              count_ff <= count_ff + 14'h1;
          end
          default: begin
            count_ff <= 14'h0;
          end
        endcase
      end
    end
  end

  // reset request, held until system reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_req_ff <= 1'b0;
    end else if (enabled && !halt_ff) begin
      if (count_ff >= code_ticks(period_ff) &&
          state_ff != wwdt_pkg::WWDT_CLOSED)
        reset_req_ff <= 1'b1;
      if (rst_apply && state_ff == wwdt_pkg::WWDT_CLOSED && windowed)
        reset_req_ff <= 1'b1;
    end
  end
  assign system_reset_req = reset_req_ff;

  // axi read
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    case (s_axi_araddr)
      wwdt_pkg::ADDR_CONFIG: rd_word[7:0] = config_ff;
      wwdt_pkg::ADDR_STATUS: begin
        rd_word[wwdt_pkg::LOCK_BIT] = lock_ff;
        rd_word[wwdt_pkg::BUSY_BIT] = cfg_busy_ff;
      end
      wwdt_pkg::ADDR_DEBUG: rd_word[wwdt_pkg::HALT_BIT] = halt_ff;
      default: rd_word = 32'h0;
    endcase
  end
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= wwdt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (s_axi_araddr[1:0] == 2'h0 &&
        s_axi_araddr <= wwdt_pkg::ADDR_DEBUG) ?
        wwdt_pkg::RESP_OKAY : wwdt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

// File: verilog/wwdt_pkg.sv
package wwdt_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_UNLOCK = 4'h8;
  localparam logic [3:0] ADDR_DEBUG = 4'hc;
  // config fields
  localparam int PERIOD_LSB = 0;
  localparam int WINDOW_LSB = 4;
  localparam int CODE_W = 4;
  localparam logic [3:0] CODE_MAX = 4'hb;
  // status fields
  localparam int BUSY_BIT = 0;
  localparam int LOCK_BIT = 7;
  // unlock key and window, in system cycles
  localparam logic [7:0] UNLOCK_KEY = 8'hd8;
  localparam int UNLOCK_CYCLES = 4;
  // debug register
  localparam int HALT_BIT = 0;
  localparam int LOCKCLR_BIT = 1;
  // counter
  localparam int CNT_W = 14;
  localparam logic [13:0] BASE_TICKS = 14'h0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    WWDT_OFF = 2'b00,
    WWDT_ARM = 2'b01,
    WWDT_CLOSED = 2'b10,
    WWDT_OPEN = 2'b11
  } wwdt_state_t;
endpackage

// File: tb/wwdt_checker.sv
`timescale 1ns/100ps
module wwdt_checker (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic system_reset_req,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_req_sticky: assert property (system_reset_req |=> system_reset_req)
    else $error("reset request dropped");
  a_req_quiet: assert property ($rose(aresetn) |-> !system_reset_req [*2])
    else $error("reset request after reset");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_w_answer: assert property (w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_r_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
  c_req: cover property (system_reset_req);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_lock: cover property (s_axi_rvalid && s_axi_rdata[7]);
endmodule

// File: tb/wwdt_core_model.sv
`timescale 1ns/100ps
module wwdt_core_model (
  // clocks
  input wire logic aclk,
  output logic watchdog_osc_clock,
  // core side
  output logic watchdog_restart_instr
);
  initial begin
    watchdog_restart_instr = 1'b0;
    watchdog_osc_clock = 1'b0;
    #37;
    forever #110 watchdog_osc_clock = ~watchdog_osc_clock;
  end
  // one-cycle restart pulse
  task kick;
    @(posedge aclk);
    watchdog_restart_instr <= 1'b1;
    @(posedge aclk);
    watchdog_restart_instr <= 1'b0;
  endtask
endmodule

// File: tb/wwdt_top_tb.sv
`timescale 1ns/100ps
module wwdt_top_tb;
  logic aclk, aresetn, watchdog_osc_clock, watchdog_restart_instr;
  logic system_reset_req;
  logic [7:0] boot_fuse_config;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int errors, samples_checked, cyc;
  wwdt_top dut (.*);
  wwdt_core_model core (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task chk_d(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_r(input logic exp);
    chk_d({31'h0, system_reset_req}, {31'h0, exp});
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk_d({30'h0, s_axi_bresp}, {30'h0, wwdt_pkg::RESP_OKAY});
  endtask
  task rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    chk_d({30'h0, s_axi_rresp}, {30'h0, wwdt_pkg::RESP_OKAY});
  endtask
  task rc(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk_d(rd_val, exp);
  endtask
  task pw(input logic [3:0] a, input logic [31:0] d);
    wr(wwdt_pkg::ADDR_UNLOCK, {24'h0, wwdt_pkg::UNLOCK_KEY});
    wr(a, d);
  endtask
  task ticks(input int n);
    repeat (n) @(posedge watchdog_osc_clock);
    @(posedge aclk);
  endtask
  task do_reset(input logic [7:0] f);
    aresetn <= 1'b0;
    boot_fuse_config <= f;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} <= 6'h3f;
    do_reset(8'h00);
    rc(wwdt_pkg::ADDR_CONFIG, 32'h00);
    rc(wwdt_pkg::ADDR_STATUS, 32'h00);
    wr(wwdt_pkg::ADDR_CONFIG, 32'h02);
    ticks(20);
    chk_r(1'b0);
    rc(wwdt_pkg::ADDR_CONFIG, 32'h00);
    pw(wwdt_pkg::ADDR_CONFIG, 32'h02);
    rc(wwdt_pkg::ADDR_STATUS, 32'h01);
    repeat (60) begin
      rd(wwdt_pkg::ADDR_STATUS);
      if (rd_val[0] === 1'b0) break;
    end
    chk_d(rd_val, 32'h00);
    rc(wwdt_pkg::ADDR_CONFIG, 32'h02);
    repeat (4) begin
      core.kick();
      ticks(8);
    end
    chk_r(1'b0);
    ticks(4);
    chk_r(1'b0);
    ticks(12);
    chk_r(1'b1);
    $display("test normal done");
    do_reset(8'h11);
    rc(wwdt_pkg::ADDR_CONFIG, 32'h11);
    rc(wwdt_pkg::ADDR_STATUS, 32'h80);
    pw(wwdt_pkg::ADDR_CONFIG, 32'h00);
    pw(wwdt_pkg::ADDR_STATUS, 32'h00);
    rc(wwdt_pkg::ADDR_CONFIG, 32'h11);
    rc(wwdt_pkg::ADDR_STATUS, 32'h80);
    core.kick();
    ticks(4);
    chk_r(1'b0);
    core.kick();
    ticks(5);
    chk_r(1'b1);
    $display("test closed done");
    do_reset(8'h11);
    core.kick();
    ticks(12);
    core.kick();
    ticks(1);
    core.kick();
    ticks(13);
    chk_r(1'b0);
    ticks(14);
    chk_r(1'b1);
    $display("test open done");
    do_reset(8'h11);
    core.kick();
    ticks(4);
    wr(wwdt_pkg::ADDR_DEBUG, 32'h01);
    ticks(30);
    chk_r(1'b0);
    pw(wwdt_pkg::ADDR_DEBUG, 32'h03);
    rc(wwdt_pkg::ADDR_STATUS, 32'h00);
    wr(wwdt_pkg::ADDR_DEBUG, 32'h00);
    ticks(12);
    chk_r(1'b1);
    $display("test debug done");
    print_verdict();
  end
endmodule
bind wwdt_top wwdt_checker chk (.*);
